// *** rtl/tmr2_timer.sv ***
// Purpose: 16-bit up timer/counter with capture or auto-reload and baud clock output.
// Assumes: Pins and register port are synchronous to clk.
// Notes: Register reads return data one cycle after the read strobe.
//
// How it works
// - Overflow sets flag unless baud select set
// - Trigger capture/reload sets external-edge flag
// - Receive select routes overflow to receive clock
// - Transmit select routes overflow to transmit clock
// - Trigger edges act only when enabled, not baud
// - Timer mode counts every two clocks
// - Counter mode counts count-pin falling edges
// - Reload mode reloads on overflow and trigger
// - Capture mode copies count on trigger
// - Baud use forces reload, ignores capture select
// - Capture/reload bytes readable, writable, reset zero
// - Count bytes readable, writable, reset zero
`default_nettype none

module tmr2_timer
	import tmr2_pkg::*;
#(
	parameter int CNT_W = TMR2_CNT_W,
	parameter int TICK_DIV = TMR2_TICK_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire tmr2_req_type req,
	output logic [7:0] rdata,
	// External pins
	input wire logic count_input_pin,
	input wire logic trigger_pin,
	// Serial port clocks, one-cycle pulses
	input wire logic other_timer_ovf,
	output tmr2_baud_type baud
);

	// ==========================================================
	// State
	logic overflow_flag_reg;
	logic external_edge_flag_reg;
	logic receive_clock_select_reg;
	logic transmit_clock_select_reg;
	logic trigger_enable_reg;
	logic run_control_reg;
	logic counter_timer_select_reg;
	logic capture_reload_select_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] capture_reload_reg;
	logic [7:0] rdata_reg;
	logic baud_rx_reg;
	logic baud_tx_reg;

	// ==========================================================
	// Event sources
	logic tick;
	logic count_fall;
	logic trig_fall;

	tmr2_prescale #(.DIV(TICK_DIV)) u_prescale (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick)
	);

	tmr2_fall_det u_count_edge (
		.clk(clk),
		.arst_n(arst_n),
		.pin(count_input_pin),
		.fall(count_fall)
	);

	tmr2_fall_det u_trig_edge (
		.clk(clk),
		.arst_n(arst_n),
		.pin(trigger_pin),
		.fall(trig_fall)
	);

	// ==========================================================
	// Counting decisions
	logic baud_mode;
	logic inc;
	logic ovf;
	logic trig_act;
	logic do_reload;
	logic do_capture;
	logic wr_ctl;
	logic wr_cnt_lo;
	logic wr_cnt_hi;
	logic wr_cr_lo;
	logic wr_cr_hi;

	assign baud_mode = receive_clock_select_reg | transmit_clock_select_reg;
	assign inc = run_control_reg
		& (counter_timer_select_reg ? count_fall : tick);
	assign ovf = inc & (count_reg == {CNT_W{1'b1}});
	assign trig_act = trig_fall & trigger_enable_reg & ~baud_mode;
	// In baud use the capture select is ignored and overflow always reloads.
	assign do_reload = ovf & (baud_mode | ~capture_reload_select_reg)
		| trig_act & ~capture_reload_select_reg;
	assign do_capture = trig_act & capture_reload_select_reg;

	assign wr_ctl = req.wr & (req.addr == TMR2_ADDR_CONTROL);
	assign wr_cnt_lo = req.wr & (req.addr == TMR2_ADDR_CNT_LOW);
	assign wr_cnt_hi = req.wr & (req.addr == TMR2_ADDR_CNT_HIGH);
	assign wr_cr_lo = req.wr & (req.addr == TMR2_ADDR_CR_LOW);
	assign wr_cr_hi = req.wr & (req.addr == TMR2_ADDR_CR_HIGH);

	// ==========================================================
	// Counter
	always_comb begin
		count_next = count_reg;
		if (do_reload) begin
			count_next = capture_reload_reg;
		end else if (inc) begin
			count_next = count_reg + CNT_W'(1);
		end
		// Software writes win over counting so a written value is never lost.
		if (wr_cnt_lo) begin
			count_next[7:0] = req.wdata;
		end
		if (wr_cnt_hi) begin
			count_next[CNT_W-1:8] = req.wdata[CNT_W-9:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// Capture/reload data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_reload_reg <= '0;
		end else if (do_capture) begin
			capture_reload_reg <= count_reg;
		end else begin
			if (wr_cr_lo) begin
				capture_reload_reg[7:0] <= req.wdata;
			end
			if (wr_cr_hi) begin
				capture_reload_reg[CNT_W-1:8] <= req.wdata[CNT_W-9:0];
			end
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			receive_clock_select_reg <= TMR2_CONTROL_RST[TMR2_BIT_RCLK];
			transmit_clock_select_reg <= TMR2_CONTROL_RST[TMR2_BIT_TRANSMIT_CLOCK_SELECT];
			trigger_enable_reg <= TMR2_CONTROL_RST[TMR2_BIT_TRIG_EN];
			run_control_reg <= TMR2_CONTROL_RST[TMR2_BIT_RUN];
			counter_timer_select_reg <= TMR2_CONTROL_RST[TMR2_BIT_CT_SEL];
			capture_reload_select_reg <= TMR2_CONTROL_RST[TMR2_BIT_CR_SEL];
		end else if (wr_ctl) begin
			receive_clock_select_reg <= req.wdata[TMR2_BIT_RCLK];
			transmit_clock_select_reg <= req.wdata[TMR2_BIT_TRANSMIT_CLOCK_SELECT];
			trigger_enable_reg <= req.wdata[TMR2_BIT_TRIG_EN];
			run_control_reg <= req.wdata[TMR2_BIT_RUN];
			counter_timer_select_reg <= req.wdata[TMR2_BIT_CT_SEL];
			capture_reload_select_reg <= req.wdata[TMR2_BIT_CR_SEL];
		end
	end

	// A hardware set in the same cycle as a software write of zero wins.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overflow_flag_reg <= TMR2_CONTROL_RST[TMR2_BIT_OVF];
		end else if (ovf & ~baud_mode) begin
			overflow_flag_reg <= 1'b1;
		end else if (wr_ctl) begin
			overflow_flag_reg <= req.wdata[TMR2_BIT_OVF];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			external_edge_flag_reg <= TMR2_CONTROL_RST[TMR2_BIT_EXF];
		end else if (trig_act) begin
			external_edge_flag_reg <= 1'b1;
		end else if (wr_ctl) begin
			external_edge_flag_reg <= req.wdata[TMR2_BIT_EXF];
		end
	end

	// ==========================================================
	// Serial baud clocks, registered one-cycle pulses
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			baud_rx_reg <= 1'b0;
			baud_tx_reg <= 1'b0;
		end else begin
			baud_rx_reg <= receive_clock_select_reg ? ovf : other_timer_ovf;
			baud_tx_reg <= transmit_clock_select_reg ? ovf : other_timer_ovf;
		end
	end

	assign baud.rx_clk = baud_rx_reg;
	assign baud.tx_clk = baud_tx_reg;

	// ==========================================================
	// Read port
	logic [7:0] control_view;

	always_comb begin
		control_view = TMR2_CONTROL_RST;
		control_view[TMR2_BIT_OVF] = overflow_flag_reg;
		control_view[TMR2_BIT_EXF] = external_edge_flag_reg;
		control_view[TMR2_BIT_RCLK] = receive_clock_select_reg;
		control_view[TMR2_BIT_TRANSMIT_CLOCK_SELECT] = transmit_clock_select_reg;
		control_view[TMR2_BIT_TRIG_EN] = trigger_enable_reg;
		control_view[TMR2_BIT_RUN] = run_control_reg;
		control_view[TMR2_BIT_CT_SEL] = counter_timer_select_reg;
		control_view[TMR2_BIT_CR_SEL] = capture_reload_select_reg;
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= TMR2_UNMAPPED_READ;
		end else if (req.rd) begin
			case (req.addr)
				TMR2_ADDR_CONTROL: rdata_reg <= control_view;
				TMR2_ADDR_CR_LOW: rdata_reg <= capture_reload_reg[7:0];
				TMR2_ADDR_CR_HIGH: rdata_reg <= capture_reload_reg[CNT_W-1:8];
				TMR2_ADDR_CNT_LOW: rdata_reg <= count_reg[7:0];
				TMR2_ADDR_CNT_HIGH: rdata_reg <= count_reg[CNT_W-1:8];
				default: rdata_reg <= TMR2_UNMAPPED_READ;
			endcase
		end else begin
			rdata_reg <= TMR2_UNMAPPED_READ;
		end
	end

	assign rdata = rdata_reg;

endmodule // tmr2_timer

`default_nettype wire

// *** rtl/tmr2_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit capture/reload timer.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes: Register offsets are byte addresses on the register port.
`default_nettype none

package tmr2_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] TMR2_ADDR_CONTROL = 8'hc8;
	localparam logic [7:0] TMR2_ADDR_CR_LOW = 8'hca;
	localparam logic [7:0] TMR2_ADDR_CR_HIGH = 8'hcb;
	localparam logic [7:0] TMR2_ADDR_CNT_LOW = 8'hcc;
	localparam logic [7:0] TMR2_ADDR_CNT_HIGH = 8'hcd;

	// ==========================================================
	// Control register fields and reset values
	localparam int TMR2_BIT_OVF = 7;
	localparam int TMR2_BIT_EXF = 6;
	localparam int TMR2_BIT_RCLK = 5;
	localparam int TMR2_BIT_TRANSMIT_CLOCK_SELECT = 4;
	localparam int TMR2_BIT_TRIG_EN = 3;
	localparam int TMR2_BIT_RUN = 2;
	localparam int TMR2_BIT_CT_SEL = 1;
	localparam int TMR2_BIT_CR_SEL = 0;
	localparam logic [7:0] TMR2_CONTROL_RST = 8'h00;
	localparam logic [7:0] TMR2_BYTE_RST = 8'h00;
	localparam logic [7:0] TMR2_UNMAPPED_READ = 8'h00;

	// ==========================================================
	// Timing: timer mode counts once every two system clocks
	localparam int TMR2_TICK_DIV = 2;
	localparam int TMR2_CNT_W = 16;
	localparam logic [15:0] TMR2_CNT_ALL_ONES = 16'hffff;

	// Register port request bundle.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr2_req_type;

	// Serial baud clock outputs.
	typedef struct packed {
		logic rx_clk;
		logic tx_clk;
	} tmr2_baud_type;

endpackage

`default_nettype wire

// *** rtl/tmr2_fall_det.sv ***
// Purpose: Falling edge detector for a pin taken as synchronous input.
// Assumes: The pin is already synchronous to clk.
// Notes: Pulse lasts one cycle, one cycle after the edge.
`default_nettype none

module tmr2_fall_det
	import tmr2_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pin and event
	input wire logic pin,
	output logic fall
);

	logic prev_reg;
	logic fall_reg;

	// Reset to high so a pin held low from reset is seen as an edge on the first clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= 1'b1;
			fall_reg <= 1'b0;
		end else begin
			prev_reg <= pin;
			fall_reg <= prev_reg & ~pin;
		end
	end

	assign fall = fall_reg;

endmodule // tmr2_fall_det

`default_nettype wire

// *** rtl/tmr2_prescale.sv ***
// Purpose: Tick generator dividing the system clock for timer mode.
// Assumes: DIV is at least 1.
// Notes: Free-running so the tick phase does not depend on control writes.
`default_nettype none

module tmr2_prescale
	import tmr2_pkg::*;
#(
	parameter int DIV = TMR2_TICK_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Tick out
	output logic tick
);

	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end

	assign tick = (cnt_reg == LAST);

endmodule // tmr2_prescale

`default_nettype wire

// *** verif/tmr2_pins_model.sv ***
// Purpose: Far-side model of the count pin, trigger pin and other timer.
// Assumes: Pins idle high and move just after a rising clock edge.
// Notes: Pin edges are only made when the bench calls a task; the other timer overflow runs free.
`default_nettype none

module tmr2_pins_model
	import tmr2_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pins toward the timer
	output logic count_input_pin,
	output logic trigger_pin,
	output logic other_timer_ovf
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Other timer overflows every fifth cycle so the routed path sees traffic.
	logic [2:0] div_reg;
	initial begin
		count_input_pin = 1'b1;
		trigger_pin = 1'b1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
		end
	end
	assign other_timer_ovf = (div_reg == 3'h4);

	// Each low is followed by a high cycle so every edge is seen apart.
	task automatic fall_count(input int n);
		repeat (n) begin
			@(posedge clk);
			count_input_pin <= 1'b0;
			@(posedge clk);
			count_input_pin <= 1'b1;
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic fall_trig();
		@(posedge clk);
		trigger_pin <= 1'b0;
		repeat (2) @(posedge clk);
		trigger_pin <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule // tmr2_pins_model

`default_nettype wire

// *** verif/tmr2_timer_sva.sv ***
// Purpose: Port-level checks of the capture/reload timer.
// Assumes: Control bits 5 to 0 change only by software writes.
// Notes: Flags and running counts are judged by the bench through reads; a stopped count low byte is checked here.
`default_nettype none

module tmr2_timer_sva
	import tmr2_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched ports
	input wire tmr2_req_type req,
	input wire logic [7:0] rdata,
	input wire logic other_timer_ovf,
	input wire tmr2_baud_type baud
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Shadows of software writes
	logic [7:0] ctl_reg;
	logic [7:0] cnt_lo_reg;
	logic frz_reg;
	logic rd_map;
	assign rd_map = req.addr inside {TMR2_ADDR_CONTROL, TMR2_ADDR_CR_LOW, TMR2_ADDR_CR_HIGH,
		TMR2_ADDR_CNT_LOW, TMR2_ADDR_CNT_HIGH};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_reg <= 8'h00;
			cnt_lo_reg <= 8'h00;
			frz_reg <= 1'b0;
		end else if (req.wr) begin
			if (req.addr == TMR2_ADDR_CONTROL) ctl_reg <= req.wdata;
			if (req.addr == TMR2_ADDR_CNT_LOW) cnt_lo_reg <= req.wdata;
			// The count is only known while stopped with the trigger off.
			if (req.addr == TMR2_ADDR_CNT_LOW) frz_reg <= (ctl_reg[3:2] == 2'h0);
			else if (req.addr == TMR2_ADDR_CONTROL && req.wdata[3:2] != 2'h0) frz_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	AST_RX_OTHER: assert property (
		!$past(ctl_reg[5]) |-> baud.rx_clk == $past(other_timer_ovf))
		else $error("receive clock not routed from other timer");
	AST_TX_OTHER: assert property (
		!$past(ctl_reg[4]) |-> baud.tx_clk == $past(other_timer_ovf))
		else $error("transmit clock not routed from other timer");
	AST_RX_TX_SAME: assert property (
		$past(ctl_reg[5] && ctl_reg[4]) |-> baud.rx_clk == baud.tx_clk)
		else $error("baud clocks differ with both selects set");
	AST_BAUD_SPACING: assert property (
		baud.tx_clk && $past(ctl_reg[4]) |=> !baud.tx_clk || !$past(ctl_reg[4]))
		else $error("own overflow pulses on adjacent cycles");
	AST_CTL_READBACK: assert property (
		$past(req.rd && req.addr == TMR2_ADDR_CONTROL) |-> rdata[5:0] == $past(ctl_reg[5:0]))
		else $error("control bits read back wrong");
	AST_COUNT_HOLD: assert property (
		$past(req.rd && req.addr == TMR2_ADDR_CNT_LOW && frz_reg) |-> rdata == $past(cnt_lo_reg))
		else $error("stopped count low byte moved");
	AST_UNMAPPED: assert property (
		$past(req.rd && !rd_map) |-> rdata == TMR2_UNMAPPED_READ)
		else $error("unmapped read not zero");
	AST_RDATA_IDLE: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside a read cycle");

	COV_OWN_BAUD: cover property (baud.rx_clk && $past(ctl_reg[5]));
	COV_HOLD: cover property ($past(req.rd && req.addr == TMR2_ADDR_CNT_LOW && frz_reg));
	COV_CAPTURE: cover property ($past(req.rd && req.addr == TMR2_ADDR_CR_LOW) && rdata != 8'h00);
endmodule // tmr2_timer_sva

bind tmr2_timer tmr2_timer_sva chk (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
	.other_timer_ovf(other_timer_ovf), .baud(baud));

`default_nettype wire

// *** verif/tmr2_timer_test.sv ***
// Purpose: Self-checking bench of the capture/reload timer.
// Assumes: Register port master moves just after rising edges.
// Notes: Run windows are whole tick pairs so the prescaler phase cancels out.
`default_nettype none

module tmr2_timer_test
	import tmr2_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	tmr2_req_type req = '0;
	logic [7:0] rdata;
	logic count_input_pin;
	logic trigger_pin;
	logic other_timer_ovf;
	tmr2_baud_type baud;
	int n_errors = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;

	tmr2_timer uut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
		.count_input_pin(count_input_pin), .trigger_pin(trigger_pin),
		.other_timer_ovf(other_timer_ovf), .baud(baud));
	tmr2_pins_model pins (.clk(clk), .arst_n(arst_n), .count_input_pin(count_input_pin),
		.trigger_pin(trigger_pin), .other_timer_ovf(other_timer_ovf));

	// ==========================================================
	// Bus tasks and verdict
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1;
		samples_checked++;
		if (rdata !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, rdata);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rdc("control", TMR2_ADDR_CONTROL, TMR2_CONTROL_RST);
		rdc("reload low", TMR2_ADDR_CR_LOW, TMR2_BYTE_RST);
		rdc("reload high", TMR2_ADDR_CR_HIGH, TMR2_BYTE_RST);
		rdc("count high", TMR2_ADDR_CNT_HIGH, TMR2_BYTE_RST);
		wr(8'hc9, 8'hff);
		rdc("unmapped", 8'hc9, TMR2_UNMAPPED_READ);
		wr(TMR2_ADDR_CNT_LOW, 8'h5a);
		rdc("count low", TMR2_ADDR_CNT_LOW, 8'h5a);
		$display("test reset done");
	endtask
	task automatic t_timer();
		wr(TMR2_ADDR_CNT_LOW, 8'hf0);
		wr(TMR2_ADDR_CNT_HIGH, 8'hff);
		wr(TMR2_ADDR_CR_LOW, 8'h34);
		wr(TMR2_ADDR_CR_HIGH, 8'h12);
		wr(TMR2_ADDR_CONTROL, 8'h04);
		repeat (14) @(posedge clk);
		wr(TMR2_ADDR_CONTROL, 8'h00);
		rdc("count low", TMR2_ADDR_CNT_LOW, 8'hf8);
		rdc("count high", TMR2_ADDR_CNT_HIGH, 8'hff);
		wr(TMR2_ADDR_CONTROL, 8'h04);
		repeat (20) @(posedge clk);
		rdc("control", TMR2_ADDR_CONTROL, 8'h84);
		wr(TMR2_ADDR_CONTROL, 8'h00);
		rdc("count low", TMR2_ADDR_CNT_LOW, 8'h38);
		rdc("count high", TMR2_ADDR_CNT_HIGH, 8'h12);
		rdc("control", TMR2_ADDR_CONTROL, 8'h00);
		$display("test timer done");
	endtask
	task automatic t_counter();
		wr(TMR2_ADDR_CNT_LOW, 8'h00);
		wr(TMR2_ADDR_CNT_HIGH, 8'h00);
		wr(TMR2_ADDR_CONTROL, 8'h06);
		pins.fall_count(5);
		wr(TMR2_ADDR_CONTROL, 8'h00);
		rdc("count low", TMR2_ADDR_CNT_LOW, 8'h05);
		$display("test counter done");
	endtask
	task automatic t_trigger();
		logic [7:0] ign [3] = '{8'h00, 8'h28, 8'h18};
		wr(TMR2_ADDR_CONTROL, 8'h09);
		pins.fall_trig();
		rdc("capture low", TMR2_ADDR_CR_LOW, 8'h05);
		rdc("control", TMR2_ADDR_CONTROL, 8'h49);
		wr(TMR2_ADDR_CR_LOW, 8'h77);
		wr(TMR2_ADDR_CR_HIGH, 8'h66);
		wr(TMR2_ADDR_CONTROL, 8'h08);
		pins.fall_trig();
		rdc("count low", TMR2_ADDR_CNT_LOW, 8'h77);
		rdc("control", TMR2_ADDR_CONTROL, 8'h48);
		for (int i = 0; i < 3; i++) begin
			wr(TMR2_ADDR_CNT_LOW, 8'h00);
			wr(TMR2_ADDR_CONTROL, ign[i]);
			pins.fall_trig();
			rdc("ignored count", TMR2_ADDR_CNT_LOW, 8'h00);
			rdc("ignored flag", TMR2_ADDR_CONTROL, ign[i]);
		end
		$display("test trigger done");
	endtask
	task automatic t_baud();
		int i = 0;
		wr(TMR2_ADDR_CNT_LOW, 8'hff);
		wr(TMR2_ADDR_CNT_HIGH, 8'hff);
		wr(TMR2_ADDR_CONTROL, 8'h35);
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (baud.rx_clk !== 1'b1 && i < 20);
		samples_checked++;
		if (baud.rx_clk !== 1'b1) begin
			n_errors++;
			$display("ERROR receive clock expected 1 seen %b", baud.rx_clk);
			summarize();
		end
		samples_checked++;
		if (baud.tx_clk !== 1'b1) begin
			n_errors++;
			$display("ERROR transmit clock expected 1 seen %b", baud.tx_clk);
		end
		rdc("control", TMR2_ADDR_CONTROL, 8'h35);
		wr(TMR2_ADDR_CONTROL, 8'h00);
		rdc("count high", TMR2_ADDR_CNT_HIGH, 8'h66);
		$display("test baud done");
	endtask

	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_timer();
		t_counter();
		t_trigger();
		t_baud();
		summarize();
	end
endmodule // tmr2_timer_test

`default_nettype wire
